// *** rtl/remap_pkg.sv ***
/*
 * constants for the bank 0 remap decoder: register values, field layouts,
 * bank numbers and target encodings.
 * assumes a 32-bit address space split into 32 banks of 128 MB.
 */
package remap_pkg;
	localparam logic [3:0] REMAP_RESET = 4'h0;
	localparam logic [7:0] REMAP_UNLOCK = 8'h3C;
	localparam logic [15:0] ROM_ORDER_UNLOCK = 16'h003C;
	localparam logic ROM_ORDER_RESET = 1'b0;
	localparam int REMAP_LSB = 0;
	localparam int ROM_ORDER_BIT = 0;
	localparam int BOOT_MIRROR_BIT = 1;
	localparam int BANK_LSB = 27;
	localparam int HALF_BIT = 26;
	localparam logic [4:0] BANK_ZERO = 5'h00;
	localparam logic [4:0] BANK_RAM = 5'h02;
	localparam logic [4:0] BANK_LOADER = 5'h09;
	localparam logic [4:0] BANK_DRAM = 5'h18;
	localparam logic [4:0] BANK_ROM = 5'h19;
	localparam logic [4:0] BANK_SRAM = 5'h1A;
	localparam logic [3:0] SEL_SRAM = 4'h8;
	localparam logic [3:0] SEL_DRAM = 4'h9;
	localparam logic [3:0] SEL_RAM10 = 4'hA;
	localparam int SETTLE_CYCLES = 4;
	localparam int SYNC_STAGES = 3;
	// one-hot target selects
	typedef enum logic [5:0] {
		TGT_NONE = 6'h01,
		TGT_ROM = 6'h02,
		TGT_SRAM = 6'h04,
		TGT_DRAM = 6'h08,
		TGT_RAM = 6'h10,
		TGT_FLASH = 6'h20
	} target_t;
endpackage : remap_pkg

// *** rtl/pin_sync.sv ***
/*
 * three-stage synchroniser for a group of slow pins; the output changes
 * once the second and third stages agree.
 * assumes pins held steady after reset, so no filter beyond that.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;
	wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					level_reg[i] <= 1'b0;
				end else if (agree[i]) begin
					level_reg[i] <= s3_reg[i];
				end
			end
		end
	endgenerate
	always_ff @(posedge clk_i) begin
		s1_reg <= pin_i;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
	end
	assign level_o = level_reg;
endmodule : pin_sync

// *** rtl/bank0_remap_decoder.sv ***
/*
 * bank 0 remap decoder: holds the write-protected remap and rom-order
 * registers, and translates addresses into a physical address plus a
 * one-hot memory select.
 * assumes a register port from the system bus with one-cycle write
 * strobes, and an address port sampled every cycle.
 */
`timescale 1ns/1ps
module bank0_remap_decoder #(
	parameter bit HAS_FLASH = 1'b1,
	parameter bit RAM_IN_BANK2 = 1'b1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] boot_select_pins_i,
	input wire logic remap_wr_i,
	input wire logic rom_order_wr_i,
	input wire logic [31:0] wdata_i,
	input wire logic [31:0] addr_i,
	input wire logic addr_valid_i,
	output logic [31:0] remap_control_reg_o,
	output logic [15:0] rom_order_reg_o,
	output logic [31:0] phys_addr_o,
	output logic [5:0] target_o,
	output logic map_settled_o
);
	logic [1:0] boot_level;
	logic [3:0] remap_select_field_reg;
	logic rom_order_bit_reg;
	logic remap_armed_reg;
	logic rom_armed_reg;
	logic [31:0] phys_addr_reg;
	logic [5:0] target_reg;
	logic [2:0] settle_reg;
	logic [2:0] settle_next;
	logic [31:0] remap_rd_reg;
	logic [15:0] rom_rd_reg;

	// boot pins come from outside, synchronised; they are static by contract
	pin_sync #(
		.WIDTH(2)
	) u_boot_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(boot_select_pins_i),
		.level_o(boot_level)
	);

	// write protection: unlock write arms, next write loads
	wire remap_unlock = remap_wr_i && wdata_i[7:0] == remap_pkg::REMAP_UNLOCK
		&& wdata_i[31:8] == 24'h000000;
	wire remap_load = remap_wr_i && remap_armed_reg;
	wire rom_unlock = rom_order_wr_i && wdata_i[15:0] == remap_pkg::ROM_ORDER_UNLOCK;
	wire rom_load = rom_order_wr_i && rom_armed_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remap_armed_reg <= 1'b0;
			rom_armed_reg <= 1'b0;
		end else begin
			// any write other than the unlock disarms, so stray sequences do nothing
			if (remap_wr_i) begin
				remap_armed_reg <= remap_unlock && !remap_armed_reg;
			end
			if (rom_order_wr_i) begin
				rom_armed_reg <= rom_unlock && !rom_armed_reg;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remap_select_field_reg <= remap_pkg::REMAP_RESET;
			rom_order_bit_reg <= remap_pkg::ROM_ORDER_RESET;
		end else begin
			if (remap_load) begin
				remap_select_field_reg <= wdata_i[remap_pkg::REMAP_LSB +: 4];
			end
			if (rom_load) begin
				rom_order_bit_reg <= wdata_i[remap_pkg::ROM_ORDER_BIT];
			end
		end
	end

	// readback; bit 1 of rom-order mirrors boot pin 0
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			remap_rd_reg <= 32'h00000000;
			rom_rd_reg <= 16'h0000;
		end else begin
			remap_rd_reg <= {28'h0000000, remap_select_field_reg};
			rom_rd_reg <= {14'h0000, boot_level[0], rom_order_bit_reg};
		end
	end
	assign remap_control_reg_o = remap_rd_reg;
	assign rom_order_reg_o = rom_rd_reg;

	// bank 0 decode
	wire [4:0] bank = addr_i[31:remap_pkg::BANK_LSB];
	wire upper_half = addr_i[remap_pkg::HALF_BIT];
	wire in_bank0 = bank == remap_pkg::BANK_ZERO;
	wire in_bank25 = bank == remap_pkg::BANK_ROM;
	wire boot_mode = boot_level[1];
	wire flash_low = rom_order_bit_reg == boot_level[0];
	wire field_hi = remap_select_field_reg[3];
	wire [1:0] field_top = remap_select_field_reg[3:2];
	wire ram_sel = field_top == 2'b11 && RAM_IN_BANK2;
	wire ram10_sel = remap_select_field_reg == remap_pkg::SEL_RAM10 && !RAM_IN_BANK2;

	// bank 0 redirect target bank, decoded from field and pins
	logic [4:0] bank0_dest;
	always_comb begin
		bank0_dest = remap_pkg::BANK_ZERO;
		if (!field_hi) begin
			bank0_dest = boot_mode ? remap_pkg::BANK_LOADER : remap_pkg::BANK_ROM;
		end else if (remap_select_field_reg == remap_pkg::SEL_SRAM) begin
			bank0_dest = remap_pkg::BANK_SRAM;
		end else if (remap_select_field_reg == remap_pkg::SEL_DRAM) begin
			bank0_dest = remap_pkg::BANK_DRAM;
		end else if (ram_sel) begin
			bank0_dest = remap_pkg::BANK_RAM;
		end
	end
	// reserved codes leave bank 0 unselected rather than guessing a memory
	wire bank0_reserved = field_hi && !ram_sel && !ram10_sel
		&& remap_select_field_reg != remap_pkg::SEL_SRAM
		&& remap_select_field_reg != remap_pkg::SEL_DRAM;

	wire [4:0] eff_bank = in_bank0 ? bank0_dest : bank;
	wire rom_window = eff_bank == remap_pkg::BANK_ROM;
	// flash occupies lower half when flash_low, else upper half
	wire hits_flash = HAS_FLASH && rom_window && (upper_half != flash_low);

	logic [5:0] target_next;
	always_comb begin
		target_next = remap_pkg::TGT_NONE;
		if (!addr_valid_i || (in_bank0 && bank0_reserved)) begin
			target_next = remap_pkg::TGT_NONE;
		end else if (in_bank0 && ram10_sel) begin
			target_next = remap_pkg::TGT_RAM;
		end else if (rom_window) begin
			// flash-less parts see rom over the whole bank
			target_next = hits_flash ? remap_pkg::TGT_FLASH : remap_pkg::TGT_ROM;
		end else if (eff_bank == remap_pkg::BANK_SRAM) begin
			target_next = remap_pkg::TGT_SRAM;
		end else if (eff_bank == remap_pkg::BANK_DRAM) begin
			target_next = remap_pkg::TGT_DRAM;
		end else if (eff_bank == remap_pkg::BANK_RAM) begin
			target_next = remap_pkg::TGT_RAM;
		end
	end

	wire [31:0] phys_next = in_bank0 ? {eff_bank, addr_i[26:0]} : addr_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phys_addr_reg <= 32'h00000000;
			target_reg <= remap_pkg::TGT_NONE;
		end else begin
			phys_addr_reg <= phys_next;
			target_reg <= target_next;
		end
	end
	assign phys_addr_o = phys_addr_reg;
	assign target_o = target_reg;

	// settle counter: decode uses the new field one cycle after the load,
	// well inside the limit; counter tells software side when it is safe
	always_comb begin
		settle_next = settle_reg;
		if (remap_load || rom_load) begin
			settle_next = 3'(remap_pkg::SETTLE_CYCLES - 1);
		end else if (settle_reg != 3'h0) begin
			settle_next = settle_reg - 3'h1;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_reg <= 3'h0;
			map_settled_o <= 1'b0;
		end else begin
			settle_reg <= settle_next;
			map_settled_o <= settle_next == 3'h0;
		end
	end
endmodule : bank0_remap_decoder

// *** bench/cpu_bus_model.sv ***
/* cpu side model: register writes, address traffic and the boot pins.
 * assumes the bench only changes the boot level while reset is held. */
`timescale 1ns/1ps
module cpu_bus_model (
	input wire logic clk_i,
	input wire logic [1:0] boot_cfg_i,
	output logic [1:0] boot_select_pins_o,
	output logic remap_wr_o = 1'b0,
	output logic rom_order_wr_o = 1'b0,
	output logic [31:0] wdata_o = 32'h0,
	output logic [31:0] addr_o = 32'h0,
	output logic addr_valid_o = 1'b0
);
	assign boot_select_pins_o = boot_cfg_i;
	task automatic put(input logic sel, input logic [31:0] v);
		@(negedge clk_i);
		remap_wr_o <= !sel;
		rom_order_wr_o <= sel;
		wdata_o <= v;
		@(negedge clk_i);
		remap_wr_o <= 1'b0;
		rom_order_wr_o <= 1'b0;
		// idle bus must not keep showing the old word
		wdata_o <= ~v;
	endtask : put
	// unlock right before the data; reserved codes are never sent
	// addr_valid_o stays high after look, so writes overlap the last bank 0 address; callers probe bank 0 before any readback
	task automatic wr(input logic sel, input logic [31:0] v);
		put(sel, 32'h0000003C);
		put(sel, v);
	endtask : wr
	task automatic look(input logic [31:0] a);
		@(negedge clk_i);
		addr_o <= a;
		addr_valid_o <= 1'b1;
	endtask : look
endmodule : cpu_bus_model

// *** bench/bank0_remap_decoder_properties.sv ***
/* assertions on the remap decoder ports.
 * assumes the default flash variant with built-in ram in bank 2. */
`timescale 1ns/1ps
module remap_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [1:0] boot_select_pins_i,
	input wire logic remap_wr_i,
	input wire logic [31:0] addr_i,
	input wire logic addr_valid_i,
	input wire logic [31:0] remap_control_reg_o,
	input wire logic [15:0] rom_order_reg_o,
	input wire logic [31:0] phys_addr_o,
	input wire logic [5:0] target_o,
	input wire logic map_settled_o
);
	logic [3:0] up_reg;
	// pins count only once the synchroniser has filled
	always_ff @(posedge clk_i) begin
		if (rst_i) up_reg <= 4'h0;
		else if (up_reg != 4'hF) up_reg <= up_reg + 4'h1;
	end
	wire [3:0] fld = remap_control_reg_o[3:0];
	wire live = addr_valid_i && map_settled_o && up_reg == 4'hF;
	wire b0 = live && addr_i[31:27] == 5'h00;
	wire same = rom_order_reg_o[0] == rom_order_reg_o[1];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_sram; b0 && fld == 4'h8 |=> phys_addr_o[31:27] == remap_pkg::BANK_SRAM; endproperty
	a_sram: assert property (p_sram) else $error("sram remap wrong");
	property p_dram; b0 && fld == 4'h9 |=> target_o == remap_pkg::TGT_DRAM; endproperty
	a_dram: assert property (p_dram) else $error("dram remap wrong");
	property p_ram; b0 && fld[3:2] == 2'b11 |=> target_o == remap_pkg::TGT_RAM; endproperty
	a_ram: assert property (p_ram) else $error("ram remap wrong");
	property p_loader;
		b0 && !fld[3] && boot_select_pins_i[1] |=> phys_addr_o[31:27] == remap_pkg::BANK_LOADER;
	endproperty
	a_loader: assert property (p_loader) else $error("loader bank wrong");
	property p_flash;
		b0 && !fld[3] && !boot_select_pins_i[1] && !addr_i[26] && same
			&& rom_order_reg_o == $past(rom_order_reg_o, 3) |=> target_o == remap_pkg::TGT_FLASH;
	endproperty
	a_flash: assert property (p_flash) else $error("flash half wrong");
	property p_bank25;
		live && addr_i[31:26] == 6'h33 && !same && rom_order_reg_o == $past(rom_order_reg_o, 3)
			|=> target_o == remap_pkg::TGT_FLASH && phys_addr_o == $past(addr_i);
	endproperty
	a_bank25: assert property (p_bank25) else $error("bank 25 halves wrong");
	property p_refuse; $changed(remap_control_reg_o) |-> $past(remap_wr_i, 2); endproperty
	a_refuse: assert property (p_refuse) else $error("remap changed without write");
	property p_settle; !map_settled_o |-> ##[1:8] map_settled_o; endproperty
	a_settle: assert property (p_settle) else $error("mapping never settled");
	c_sram: cover property (b0 && fld == 4'h8);
	c_loader: cover property (b0 && boot_select_pins_i[1]);
	c_settle: cover property ($fell(map_settled_o));
endmodule : remap_checker
bind bank0_remap_decoder remap_checker chk (.clk_i(clk_i), .rst_i(rst_i),
	.boot_select_pins_i(boot_select_pins_i), .remap_wr_i(remap_wr_i), .addr_i(addr_i),
	.addr_valid_i(addr_valid_i), .remap_control_reg_o(remap_control_reg_o),
	.rom_order_reg_o(rom_order_reg_o), .phys_addr_o(phys_addr_o), .target_o(target_o),
	.map_settled_o(map_settled_o));

// *** bench/tb_bank0_remap_decoder.sv ***
/* self-checking bench for the remap decoder with the cpu model.
 * assumes default parameters; flash-less, RAM_IN_BANK2-off and reserved-code cases go unexercised. */
`timescale 1ns/1ps
module tb_bank0_remap_decoder;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] cfg = 2'b00;
	logic [1:0] pins;
	logic rwr, owr, av, settled;
	logic [31:0] wd, ad, rmp, phys;
	logic [15:0] rom;
	logic [5:0] tgt;
	int mismatches = 0;
	int checks_done = 0;
	localparam logic [3:0] fld_tab [4] = '{4'h8, 4'h9, 4'hC, 4'hF};
	localparam logic [5:0] tgt_tab [4] = '{remap_pkg::TGT_SRAM, remap_pkg::TGT_DRAM,
		remap_pkg::TGT_RAM, remap_pkg::TGT_RAM};
	localparam logic [4:0] bank_tab [4] = '{5'h1A, 5'h18, 5'h02, 5'h02};
	always #50 clk_i = ~clk_i;
	cpu_bus_model cpu (.clk_i(clk_i), .boot_cfg_i(cfg), .boot_select_pins_o(pins),
		.remap_wr_o(rwr), .rom_order_wr_o(owr), .wdata_o(wd), .addr_o(ad), .addr_valid_o(av));
	bank0_remap_decoder uut (.clk_i(clk_i), .rst_i(rst_i), .boot_select_pins_i(pins),
		.remap_wr_i(rwr), .rom_order_wr_i(owr), .wdata_i(wd), .addr_i(ad), .addr_valid_i(av),
		.remap_control_reg_o(rmp), .rom_order_reg_o(rom), .phys_addr_o(phys),
		.target_o(tgt), .map_settled_o(settled));
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic boot(input logic [1:0] c);
		@(negedge clk_i);
		rst_i = 1'b1;
		cfg = c;
		repeat (12) @(negedge clk_i);
		rst_i = 1'b0;
		repeat (8) @(negedge clk_i);
		chk("remap", rmp, 32'h0);
		chk("rom order", {16'h0, rom}, {30'h0, c[0], 1'b0});
		chk("settled", {31'h0, settled}, 32'h1);
	endtask : boot
	// three edges after a load, inside the four-cycle limit
	task automatic probe(input logic [31:0] a, input logic [5:0] t, input logic [31:0] p);
		cpu.look(a);
		repeat (2) @(negedge clk_i);
		chk("target", {26'h0, tgt}, {26'h0, t});
		chk("phys", phys, p);
	endtask : probe
	task automatic t_flash_boot;
		boot(2'b00);
		probe(32'h00000010, remap_pkg::TGT_FLASH, 32'hC8000010);
		probe(32'h04000000, remap_pkg::TGT_ROM, 32'hCC000000);
		probe(32'hCC000004, remap_pkg::TGT_ROM, 32'hCC000004);
	endtask : t_flash_boot
	task automatic t_pin0;
		boot(2'b01);
		probe(32'h00000000, remap_pkg::TGT_ROM, 32'hC8000000);
		cpu.wr(1'b1, 32'h1);
		probe(32'h00000000, remap_pkg::TGT_FLASH, 32'hC8000000);
	endtask : t_pin0
	task automatic t_loader;
		boot(2'b10);
		cpu.look(32'h00000040);
		repeat (2) @(negedge clk_i);
		chk("phys", phys, 32'h48000040);
	endtask : t_loader
	task automatic t_remap;
		boot(2'b00);
		cpu.put(1'b0, 32'h8);
		repeat (4) @(negedge clk_i);
		chk("remap", rmp, 32'h0);
		for (int i = 0; i < 4; i++) begin
			cpu.wr(1'b0, {28'h0, fld_tab[i]});
			probe(32'h00000100, tgt_tab[i], {bank_tab[i], 27'h100});
			chk("remap", rmp, {28'h0, fld_tab[i]});
		end
		cpu.wr(1'b0, 32'h0);
		// the load edge has just passed, so the update is still settling
		chk("settled", {31'h0, settled}, 32'h0);
		probe(32'h00000000, remap_pkg::TGT_FLASH, 32'hC8000000);
		chk("settled", {31'h0, settled}, 32'h1);
	endtask : t_remap
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	initial begin
		t_flash_boot();
		t_pin0();
		t_loader();
		t_remap();
		summarize();
	end
	// run needs well under a thousand cycles
	initial begin
		#1000000;
		mismatches++;
		summarize();
	end
endmodule : tb_bank0_remap_decoder
